// ---- core/mdio_pkg.sv ----
// shared constants for the serial management slave and its station controller
// assumes both ends and the bench run on one 20 MHz core clock
package mdio_pkg;
  // frame field widths and interrupt count
  localparam int PHY_ADDR_W = 5;
  localparam int REG_ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_IRQ = 9;
  localparam int PRE_BITS = 32;
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 12;
  localparam int TA_BITS = 2;
  // bits left after a foreign start pattern, and after a header not for us
  localparam int SKIP_C45 = FRAME_BITS - 2;
  localparam int SKIP_HDR = TA_BITS + DATA_W;
  // frame codes
  localparam logic [1:0] ST_C22 = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  // device register map
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h18;
  localparam logic [4:0] REG_IRQ_CAUSE = 5'h19;
  localparam logic [8:0] IRQ_ENABLE_RST = 9'h000;
  localparam logic [8:0] IRQ_CAUSE_RST = 9'h000;
  // controller register map (apb byte addresses)
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STAT = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_CFG = 8'h0C;
  localparam int CMD_REG_LSB = 16;
  localparam int CMD_PHY_LSB = 21;
  localparam int CMD_READ_BIT = 26;
  localparam int CFG_PRE_BIT = 0;
  localparam int CFG_DIV_LSB = 8;
  // management clock rates and derived half periods in core cycles
  localparam int CORE_CLK_KHZ = 20000;
  localparam int MDC_NOM_KHZ = 2500;
  localparam int MDC_MAX_KHZ = 12500;
  localparam int MDC_HALF_CYC = CORE_CLK_KHZ / (2 * MDC_NOM_KHZ);
  localparam int MDC_MIN_HALF = (CORE_CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam logic [7:0] CFG_DIV_RST = 8'(MDC_HALF_CYC);
  localparam logic CFG_PRE_RST = 1'b1;
endpackage

// ---- core/mdio_link_if.sv ----
// three-wire management link between station controller and slave
// assumes pull-ups on the data and interrupt wires; no end drives high-z
interface mdio_link_if;
  logic mdc;
  logic mdio;
  logic irq_n;
  logic ctl_mdio_o;
  logic ctl_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic dev_irq_o;
  logic dev_irq_oe;
  // wired level: an undriven wire reads one through its pull-up
  assign mdio = (~ctl_mdio_oe | ctl_mdio_o) & (~dev_mdio_oe | dev_mdio_o);
  assign irq_n = ~dev_irq_oe | dev_irq_o;
  modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe,
               output dev_irq_o, output dev_irq_oe);
  modport ctl (output mdc, input mdio, input irq_n, output ctl_mdio_o, output ctl_mdio_oe);
endinterface

// ---- core/mdio_mgmt_slave.sv ----
// management slave end: frame decoder, interrupt mask and cause registers
// assumes mdc and mdio arrive asynchronously and are resynchronised here;
// other registers live in user logic behind the plain register port

// Function
// - frame starts only on 01 pattern
// - 00 start: ignore frame, never drive
// - opcode 10 reads, 01 writes
// - preamble optional, frames without accepted
// - answer only own address, msb first
// - five-bit register address, msb first
// - read turnaround: release, then drive zero
// - write turnaround sent as one, zero
// - sixteen data bits, msb first
// - data line released between frames
// - address latched from straps at reset
// - controller supplies clock, may stop it
// - bits sampled and sent per mdc
// - open-drain low interrupt, unmasked pending only
// - nine interrupt conditions provided
// - mask register 24 gates each condition
// - condition sets its bit in register 25
// - reading register 25 clears returned bits
module mdio_mgmt_slave
  import mdio_pkg::*;
#(
  parameter int STRAP_W = PHY_ADDR_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [STRAP_W-1:0] i_mgmt_addr_strap,
  input wire logic [NUM_IRQ-1:0] i_irq_events,
  output logic [REG_ADDR_W-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [DATA_W-1:0] o_reg_wdata,
  input wire logic [DATA_W-1:0] i_reg_rdata,
  mdio_link_if.dev link
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_HDR, S_TA, S_DATA, S_SKIP} dev_state_type;

  dev_state_type state;
  logic [2:0] mdc_sync;
  logic [1:0] mdio_sync;
  logic mdc_rise;
  logic mdio_bit;
  logic [PHY_ADDR_W-1:0] phy_addr;
  logic [4:0] cnt;
  logic [HDR_BITS-1:0] hdr;
  logic [HDR_BITS-1:0] next_hdr;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] next_sh;
  logic [DATA_W-1:0] rd_value;
  logic is_read;
  logic hit;
  logic wr_now;
  logic cause_clr;
  logic [NUM_IRQ-1:0] irq_enable_bits;
  logic [NUM_IRQ-1:0] irq_cause_flags;
  logic [NUM_IRQ-1:0] cause_snap;
  logic mdio_o;
  logic mdio_oe;
  logic irq_oe;

  // two flops per input; the third mdc stage only feeds edge detection
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mdc_sync <= 3'h0;
      mdio_sync <= 2'h3;
    end else begin
      mdc_sync <= {mdc_sync[1:0], link.mdc};
      mdio_sync <= {mdio_sync[0], link.mdio};
    end
  end

  // bit timing follows the controller clock, whenever it runs
  assign mdc_rise = mdc_sync[1] & ~mdc_sync[2];
  assign mdio_bit = mdio_sync[1];

  // own address caught from the straps while reset is held
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phy_addr <= PHY_ADDR_W'(i_mgmt_addr_strap);
    end
  end

  // header shift and address match, both fields msb first
  assign next_hdr = {hdr[HDR_BITS-2:0], mdio_bit};
  assign hit = (next_hdr[9:5] == phy_addr)
               && (next_hdr[11:10] == OP_READ || next_hdr[11:10] == OP_WRITE);
  assign next_sh = {sh[DATA_W-2:0], mdio_bit};

  // read source: the two local registers, else the user register port
  always_comb begin
    unique case (o_reg_addr)
      REG_IRQ_ENABLE: rd_value = DATA_W'(irq_enable_bits);
      REG_IRQ_CAUSE: rd_value = DATA_W'(irq_cause_flags);
      default: rd_value = i_reg_rdata;
    endcase
  end

  // end of the data field in either direction
  assign wr_now = mdc_rise && state == S_DATA && cnt == 5'(DATA_W - 1) && !is_read;
  assign cause_clr = mdc_rise && state == S_DATA && cnt == 5'(DATA_W - 1) && is_read
                     && o_reg_addr == REG_IRQ_CAUSE;

  // frame decoder, advanced once per detected mdc rising edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
      cnt <= 5'h00;
      hdr <= '0;
      sh <= '0;
      is_read <= 1'b0;
      o_reg_addr <= '0;
      cause_snap <= '0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state)
        // ones of a preamble or idle are passed over
        S_IDLE: begin
          if (!mdio_bit) begin
            state <= S_START;
          end
        end
        // second start bit: 1 opens a frame, 0 marks a foreign one
        S_START: begin
          if (mdio_bit) begin
            state <= S_HDR;
            cnt <= 5'h00;
          end else begin
            state <= S_SKIP;
            cnt <= 5'(SKIP_C45 - 1);
          end
        end
        // opcode, phy address, register address
        S_HDR: begin
          hdr <= next_hdr;
          if (cnt == 5'(HDR_BITS - 1)) begin
            cnt <= 5'h00;
            if (hit) begin
              state <= S_TA;
              is_read <= next_hdr[11:10] == OP_READ;
              o_reg_addr <= next_hdr[4:0];
            end else begin
              state <= S_SKIP;
              cnt <= 5'(SKIP_HDR - 1);
            end
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        // first turnaround bit left undriven, zero driven in the second
        S_TA: begin
          if (cnt == 5'h00) begin
            cnt <= 5'h01;
            if (is_read) begin
              sh <= rd_value;
              cause_snap <= irq_cause_flags;
              mdio_oe <= 1'b1;
              mdio_o <= 1'b0;
            end
          end else begin
            cnt <= 5'h00;
            state <= S_DATA;
            sh <= next_sh;
            mdio_o <= sh[DATA_W-1];
          end
        end
        // data msb first; reads shift out, writes shift in
        S_DATA: begin
          sh <= next_sh;
          if (cnt == 5'(DATA_W - 1)) begin
            state <= S_IDLE;
            mdio_oe <= 1'b0;
            mdio_o <= 1'b0;
          end else begin
            cnt <= cnt + 5'h01;
            mdio_o <= sh[DATA_W-1];
          end
        end
        // rest of a frame that is not ours, line never driven
        S_SKIP: begin
          if (cnt == 5'h00) begin
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
      endcase
    end
  end

  // write strobe to user registers, one core cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_wr <= 1'b0;
      o_reg_wdata <= '0;
    end else begin
      o_reg_wr <= wr_now;
      if (wr_now) begin
        o_reg_wdata <= next_sh;
      end
    end
  end

  // interrupt enable register, written by management frames
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_enable_bits <= IRQ_ENABLE_RST;
    end else if (wr_now && o_reg_addr == REG_IRQ_ENABLE) begin
      irq_enable_bits <= next_sh[NUM_IRQ-1:0];
    end
  end

  // sticky causes; a new event in the clearing cycle survives
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_cause_flags <= IRQ_CAUSE_RST;
    end else begin
      irq_cause_flags <= (irq_cause_flags & ~(cause_clr ? cause_snap : '0))
                         | i_irq_events;
    end
  end

  // pull the shared interrupt wire low while an enabled cause is pending
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= |(irq_cause_flags & irq_enable_bits);
    end
  end

  // pin drivers: only ever drive low on the interrupt wire
  assign link.dev_mdio_o = mdio_o;
  assign link.dev_mdio_oe = mdio_oe;
  assign link.dev_irq_o = 1'b0;
  assign link.dev_irq_oe = irq_oe;
endmodule // mdio_mgmt_slave

// ---- core/mdio_station_ctl.sv ----
// station controller end: apb-programmed clause 22 frame generator
// assumes apb on the core clock; the slave resamples mdc and mdio itself
module mdio_station_ctl
  import mdio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  mdio_link_if.ctl link
);
  logic [1:0] mdio_sync;
  logic [1:0] irq_sync;
  logic busy;
  logic done;
  logic mdc;
  logic cfg_pre;
  logic [7:0] cfg_div;
  logic [7:0] half_cnt;
  logic [7:0] div_eff;
  logic tick;
  logic [6:0] cnt;
  logic [63:0] tx_sh;
  logic [63:0] oe_sh;
  logic [DATA_W-1:0] rd_data;
  logic [31:0] frame;
  logic [31:0] oe_frame;
  logic rd_cmd;
  logic start;
  logic mapped;

  // resynchronise the wires coming back from the slave
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mdio_sync <= 2'h3;
      irq_sync <= 2'h3;
    end else begin
      mdio_sync <= {mdio_sync[0], link.mdio};
      irq_sync <= {irq_sync[0], link.irq_n};
    end
  end

  // apb decode; zero wait states, unmapped offsets answer with pslverr
  assign mapped = i_paddr == APB_CMD || i_paddr == APB_STAT || i_paddr == APB_RDATA
                  || i_paddr == APB_CFG;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign start = i_psel & i_penable & i_pwrite & i_paddr == APB_CMD & ~busy;

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        APB_STAT: o_prdata <= {29'h0, ~irq_sync[1], done, busy};
        APB_RDATA: o_prdata <= 32'(rd_data);
        APB_CFG: o_prdata <= {16'h0, cfg_div, 7'h0, cfg_pre};
        default: o_prdata <= 32'h0;
      endcase
    end
  end

  // configuration: preamble enable and mdc half period
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg_pre <= CFG_PRE_RST;
      cfg_div <= CFG_DIV_RST;
    end else if (i_psel && i_penable && i_pwrite && i_paddr == APB_CFG) begin
      cfg_pre <= i_pwdata[CFG_PRE_BIT];
      cfg_div <= i_pwdata[CFG_DIV_LSB +: 8];
    end
  end

  // frame image: start, opcode, addresses, turnaround, data
  assign rd_cmd = i_pwdata[CMD_READ_BIT];
  assign frame = {ST_C22, rd_cmd ? OP_READ : OP_WRITE,
                  i_pwdata[CMD_PHY_LSB +: PHY_ADDR_W], i_pwdata[CMD_REG_LSB +: REG_ADDR_W],
                  rd_cmd ? 2'h0 : TA_WRITE, rd_cmd ? 16'h0 : i_pwdata[15:0]};
  assign oe_frame = rd_cmd ? {{(HDR_BITS + 2){1'b1}}, {SKIP_HDR{1'b0}}} : 32'hFFFFFFFF;

  // half-period divider, clamped to the fastest legal mdc
  assign div_eff = (cfg_div < 8'(MDC_MIN_HALF)) ? 8'(MDC_MIN_HALF) : cfg_div;
  assign tick = busy && half_cnt == 8'h00;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !busy || tick) begin
      half_cnt <= div_eff - 8'h01;
    end else begin
      half_cnt <= half_cnt - 8'h01;
    end
  end

  // sequencer: data sampled at mdc rise, next bit put out at mdc fall
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      mdc <= 1'b0;
      cnt <= 7'h00;
      tx_sh <= 64'h0;
      oe_sh <= 64'h0;
      rd_data <= '0;
    end else if (start) begin
      busy <= 1'b1;
      done <= 1'b0;
      mdc <= 1'b0;
      if (cfg_pre) begin
        tx_sh <= {32'hFFFFFFFF, frame};
        oe_sh <= {32'hFFFFFFFF, oe_frame};
        cnt <= 7'(PRE_BITS + FRAME_BITS);
      end else begin
        tx_sh <= {frame, 32'h0};
        oe_sh <= {oe_frame, 32'h0};
        cnt <= 7'(FRAME_BITS);
      end
    end else if (tick) begin
      mdc <= ~mdc;
      if (!mdc) begin
        if (!oe_sh[63]) begin
          rd_data <= {rd_data[DATA_W-2:0], mdio_sync[1]};
        end
      end else begin
        tx_sh <= {tx_sh[62:0], 1'b0};
        oe_sh <= {oe_sh[62:0], 1'b0};
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // link drivers straight from flops
  assign link.mdc = mdc;
  assign link.ctl_mdio_o = tx_sh[63];
  assign link.ctl_mdio_oe = oe_sh[63];
endmodule // mdio_station_ctl

// ---- tb/mdio_link_properties.sv ----
// checker of the management link wires between controller and slave
// assumes the controller runs its reset divider: four core cycles per mdc phase
module mdio_link_properties (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic mdc,
  input wire logic mdio,
  input wire logic irq_n,
  input wire logic ctl_mdio_o,
  input wire logic ctl_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic dev_irq_o,
  input wire logic dev_irq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DRV_MIN = 130;
  localparam int DRV_MAX = 140;
  int drv_cnt;
  int idle_cnt;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // cycles the slave has held the data wire in one stretch
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !dev_mdio_oe) drv_cnt <= 0;
    else drv_cnt <= drv_cnt + 1;
  end
  // cycles mdc has stayed low, saturating; longer than a half period means no frame
  always_ff @(posedge i_core_clk) begin
    if (i_rst || mdc) idle_cnt <= 0;
    else if (idle_cnt < 15) idle_cnt <= idle_cnt + 1;
  end
  sequence s_mdc_high;
    mdc [*4] ##1 !mdc;
  endsequence
  sequence s_ta_zero;
    !dev_mdio_o && !ctl_mdio_oe && !$past(ctl_mdio_oe, 4);
  endsequence
  property p_no_contention;
    !(dev_mdio_oe && ctl_mdio_oe);
  endproperty
  property p_ta_zero;
    $rose(dev_mdio_oe) |-> s_ta_zero;
  endproperty
  property p_drive_len;
    $fell(dev_mdio_oe) |-> drv_cnt inside {[DRV_MIN:DRV_MAX]};
  endproperty
  property p_release_idle;
    $fell(dev_mdio_oe) |-> !ctl_mdio_oe ##1 !dev_mdio_oe;
  endproperty
  property p_after_rise;
    ($changed(dev_mdio_o) && dev_mdio_oe) || $changed(dev_mdio_oe) |-> mdc;
  endproperty
  property p_mdc_half;
    $rose(mdc) |-> s_mdc_high;
  endproperty
  property p_irq_low;
    dev_irq_oe |-> !dev_irq_o && !irq_n;
  endproperty
  property p_idle_high;
    idle_cnt > 6 && !ctl_mdio_oe |-> !dev_mdio_oe && mdio;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("both ends drive mdio");
  a_ta_zero: assert property (p_ta_zero) else $error("bad read turnaround");
  a_drive_len: assert property (p_drive_len) else $error("read drive length wrong");
  a_release_idle: assert property (p_release_idle) else $error("mdio not released");
  a_after_rise: assert property (p_after_rise) else $error("slave bit not after mdc rise");
  a_mdc_half: assert property (p_mdc_half) else $error("mdc high phase wrong");
  a_irq_low: assert property (p_irq_low) else $error("irq not pulled low");
  a_idle_high: assert property (p_idle_high) else $error("idle mdio not high");
endmodule // mdio_link_properties

// ---- tb/mdio_mgmt_slave_with_irq_tb_top.sv ----
// bench: controller and slave on one link, a second slave on a link driven by the bench
// assumes the reset divider of four and a 20 MHz core clock
module mdio_mgmt_slave_with_irq_tb_top import mdio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, reg_wr, b_drove = 1'b0;
  logic [4:0] strap = 5'h05, reg_addr;
  logic [8:0] events = 9'h000;
  logic [15:0] reg_wdata;
  logic [15:0] user_regs [32];
  int err_count = 0, check_count = 0;
  mdio_link_if link();
  mdio_link_if link_b();
  mdio_station_ctl i_mdio_station_ctl (.i_core_clk, .i_rst, .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link.ctl));
  mdio_mgmt_slave i_mdio_mgmt_slave (.i_core_clk, .i_rst, .i_mgmt_addr_strap(strap),
    .i_irq_events(events), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(user_regs[reg_addr]), .link(link.dev));
  mdio_mgmt_slave i_mdio_mgmt_slave_b (.i_core_clk, .i_rst, .i_mgmt_addr_strap(strap),
    .i_irq_events(9'h000), .o_reg_addr(), .o_reg_wr(), .o_reg_wdata(),
    .i_reg_rdata(16'h0000), .link(link_b.dev));
  mdio_link_properties i_mdio_link_properties (.i_core_clk, .i_rst, .mdc(link.mdc),
    .mdio(link.mdio), .irq_n(link.irq_n), .ctl_mdio_o(link.ctl_mdio_o),
    .ctl_mdio_oe(link.ctl_mdio_oe), .dev_mdio_o(link.dev_mdio_o),
    .dev_mdio_oe(link.dev_mdio_oe), .dev_irq_o(link.dev_irq_o), .dev_irq_oe(link.dev_irq_oe));
  // core clock
  initial forever #25 i_core_clk = ~i_core_clk;
  // user registers behind the slave, and a sticky flag of drive on the second link
  always @(posedge i_core_clk) begin
    if (reg_wr === 1'b1) user_regs[reg_addr] <= reg_wdata;
    if (link_b.dev_mdio_oe === 1'b1) b_drove <= 1'b1;
  end
  task automatic report_and_stop(input bit tmo);
    if (tmo) err_count++;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; read data and error flag land in q and e
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge i_core_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 16) report_and_stop(1'b1);
  endtask
  // one management frame through the controller; read data ends in q
  task automatic mdio_op(input logic rd, input logic [4:0] phy, ra, input logic [15:0] d);
    int n;
    apb(1'b1, APB_CMD, {5'h00, rd, phy, ra, d});
    for (n = 0; n < 400; n++) begin
      apb(1'b0, APB_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (n == 400) report_and_stop(1'b1);
    `CHK("done", 1'b1, q[1])
    apb(1'b0, APB_RDATA, 32'h0);
  endtask
  // one interrupt event pulse, then time for cause and pin to follow
  task automatic fire(input int k);
    @(posedge i_core_clk) events <= 9'(1 << k);
    @(posedge i_core_clk) events <= 9'h000;
    repeat (4) @(posedge i_core_clk);
  endtask
  // bench-driven frame on the second link, released from the turnaround on
  task automatic send_b(input logic [31:0] v);
    for (int i = 31; i >= 0; i--) begin
      @(posedge i_core_clk);
      link_b.ctl_mdio_o <= v[i]; link_b.ctl_mdio_oe <= (i >= 18); link_b.mdc <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      link_b.mdc <= 1'b1;
      repeat (3) @(posedge i_core_clk);
    end
    @(posedge i_core_clk) link_b.mdc <= 1'b0;
    link_b.ctl_mdio_oe <= 1'b0;
  endtask
  // main sequence
  initial begin
    link_b.mdc = 1'b0; link_b.ctl_mdio_o = 1'b0; link_b.ctl_mdio_oe = 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0; strap <= 5'h1A;
    repeat (2) @(posedge i_core_clk);
    `CHK("mdc idle", 1'b0, link.mdc)
    `CHK("mdio idle", 1'b1, link.mdio)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pslverr", 1'b1, e)
    apb(1'b0, APB_CFG, 32'h0);
    `CHK("cfg reset", 32'h00000401, q)
    mdio_op(1'b0, 5'h05, 5'h03, 16'hA5C3);
    `CHK("user reg 3", 16'hA5C3, user_regs[3])
    mdio_op(1'b1, 5'h05, 5'h03, 16'h0000);
    `CHK("read reg 3", 16'hA5C3, q[15:0])
    apb(1'b1, APB_CFG, 32'h00000400);
    mdio_op(1'b0, 5'h05, 5'h1F, 16'h8001);
    `CHK("user reg 31", 16'h8001, user_regs[31])
    mdio_op(1'b1, 5'h05, 5'h1F, 16'h0000);
    `CHK("read reg 31", 16'h8001, q[15:0])
    apb(1'b1, APB_CFG, 32'h00000401);
    mdio_op(1'b0, 5'h1A, 5'h03, 16'h1234);
    `CHK("foreign write", 16'hA5C3, user_regs[3])
    mdio_op(1'b1, 5'h1A, 5'h03, 16'h0000);
    `CHK("foreign read", 16'hFFFF, q[15:0])
    mdio_op(1'b1, 5'h05, REG_IRQ_ENABLE, 16'h0000);
    `CHK("mask reset", 16'h0000, q[15:0])
    for (int k = 0; k < NUM_IRQ; k++) begin
      fire(k);
      `CHK("irq masked", 1'b1, link.irq_n)
      mdio_op(1'b1, 5'h05, REG_IRQ_CAUSE, 16'h0000);
      `CHK("cause bit", 16'(1 << k), q[15:0])
    end
    mdio_op(1'b1, 5'h05, REG_IRQ_CAUSE, 16'h0000);
    `CHK("cause cleared", 16'h0000, q[15:0])
    mdio_op(1'b0, 5'h05, REG_IRQ_ENABLE, 16'hFE02);
    mdio_op(1'b1, 5'h05, REG_IRQ_ENABLE, 16'h0000);
    `CHK("mask readback", 16'h0002, q[15:0])
    fire(0);
    `CHK("irq bit0 masked", 1'b1, link.irq_n)
    fire(1);
    `CHK("irq low", 1'b0, link.irq_n)
    apb(1'b0, APB_STAT, 32'h0);
    `CHK("irq pending", 1'b1, q[2])
    mdio_op(1'b1, 5'h05, REG_IRQ_CAUSE, 16'h0000);
    `CHK("cause both", 16'h0003, q[15:0])
    repeat (4) @(posedge i_core_clk);
    `CHK("irq released", 1'b1, link.irq_n)
    send_b({2'b00, OP_READ, 5'h05, 5'h03, 18'h3FFFF});
    `CHK("foreign start", 1'b0, b_drove)
    send_b({ST_C22, 2'b11, 5'h05, 5'h03, 18'h3FFFF});
    `CHK("bad opcode", 1'b0, b_drove)
    send_b({ST_C22, OP_READ, 5'h05, 5'h03, 18'h3FFFF});
    `CHK("own start", 1'b1, b_drove)
    report_and_stop(1'b0);
  end
endmodule // mdio_mgmt_slave_with_irq_tb_top
